// *** verilog/gpx_port.sv ***
// Purpose: 8-pin gpio port with alternate functions and external irq
// Assumes: pins and alt signals synchronous to pclk
// Notes: pad oe_n low means the pad drives o
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps

module gpx_port
    import gpx_pkg::*;
#(
    parameter int NPINS = GPX_PINS,
    parameter logic [2*GPX_PINS-1:0] PIN_KIND = {8{GPX_KIND_IRQ_PU}}
) (
    input wire logic pclk,                     // bus clock
    input wire logic presetn,                  // async reset, low
    input wire logic psel,                     // apb select
    input wire logic penable,                  // apb access phase
    input wire logic pwrite,                   // apb direction
    input wire logic [11:0] paddr,             // apb byte address
    input wire logic [31:0] pwdata,            // apb write data
    input wire logic [3:0] pstrb,              // apb byte strobes
    output logic [31:0] prdata,                // apb read data
    output logic pready,                       // apb ready
    output logic pslverr,                      // apb error
    input wire logic [NPINS-1:0] pin_i,        // pin levels
    output gpx_pad_t [NPINS-1:0] pad_o,        // pad controls
    input wire gpx_alt_t [NPINS-1:0] alt_i,    // peripheral claims
    output logic [NPINS-1:0] alt_in_o,         // levels to peripherals
    input wire logic cpu_irq_masked,           // cpu interrupt mask set
    input wire logic vector_fetch,             // irq vector fetched, pulse
    output logic ext_irq_req,                  // request to cpu
    output logic wake_req                      // wake from wait/halt
);
    logic [NPINS-1:0] port_value_reg_r;
    logic [NPINS-1:0] pin_direction_r;
    logic [NPINS-1:0] pin_option_r;
    logic [1:0] ext_irq_sensitivity_ctrl_r;
    logic [NPINS-1:0] pin_prev_r;
    logic pend_r;
    logic pend_nxt;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;

    // apb decode
    wire logic acc = psel && penable;
    wire logic wr_acc = acc && pwrite && pstrb[0];
    wire logic hit_value = (paddr == GPX_OFF_VALUE);
    wire logic hit_dir = (paddr == GPX_OFF_DIR);
    wire logic hit_opt = (paddr == GPX_OFF_OPT);
    wire logic hit_sens = (paddr == GPX_OFF_SENS);
    wire logic hit_pend = (paddr == GPX_OFF_PEND);
    wire logic hit_any = hit_value | hit_dir | hit_opt | hit_sens | hit_pend;
    wire logic sens_wr = wr_acc && hit_sens;
    wire logic [NPINS-1:0] irq_mode;
    wire logic [NPINS-1:0] qual_evt;
    wire logic [NPINS-1:0] rd_value;
    wire logic any_evt = |qual_evt;

    // per-pin mode decode and pad drive
    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            wire logic [1:0] kind = PIN_KIND[2*g +: 2];
            wire logic tod = (kind == GPX_KIND_TOD);
            wire logic irq_cap = (kind == GPX_KIND_IRQ_PU) || (kind == GPX_KIND_IRQ_FL);
            wire logic dir = pin_direction_r[g];
            wire logic opt = pin_option_r[g];
            // alt drive wins over gpio setup
            wire logic drv = alt_i[g].out_en || dir;
            wire logic val = alt_i[g].out_en ? alt_i[g].out_val : port_value_reg_r[g];
            // push-pull with opt set or on alt push-pull drive, never on true open-drain
            wire logic pp = alt_i[g].out_en ? (!alt_i[g].out_od && !tod)
                                            : (opt && !tod);
            wire logic pu = !drv && opt && !tod && (kind != GPX_KIND_IRQ_FL);
            assign irq_mode[g] = irq_cap && !dir && opt;
            assign pad_o[g].o = val;
            // pad driven for push-pull, or for low on open-drain
            assign pad_o[g].oe_n = !(drv && (pp || !val));
            assign pad_o[g].pull_up = pu;
            // reads: latch in output, alt output or pin in input
            assign rd_value[g] = dir ? port_value_reg_r[g]
                               : (alt_i[g].out_en ? alt_i[g].out_val
                                                  : pin_i[g]);
            assign alt_in_o[g] = dir ? port_value_reg_r[g] : pin_i[g];
        end
    endgenerate

    // per-pin qualification by group sensitivity
    generate
        for (g = 0; g < NPINS; g++) begin : g_evt
            wire logic rise = pin_i[g] && !pin_prev_r[g];
            wire logic fall = !pin_i[g] && pin_prev_r[g];
            wire logic hit = (ext_irq_sensitivity_ctrl_r == GPX_SENS_FALL_LOW) ? !pin_i[g]
                           : (ext_irq_sensitivity_ctrl_r == GPX_SENS_RISE) ? rise
                           : (ext_irq_sensitivity_ctrl_r == GPX_SENS_FALL) ? fall
                           : (rise || fall);
            assign qual_evt[g] = irq_mode[g] && hit;
        end
    endgenerate

    // pending latch: event sets, fetch or sensitivity write clears, set wins
    assign pend_nxt = any_evt ? 1'b1
                    : ((vector_fetch || sens_wr) ? 1'b0 : pend_r);

    assign ext_irq_req = pend_r && !cpu_irq_masked;
    assign wake_req = pend_r;

    // read mux, pending latch reads as zero
    assign rd_mux = hit_value ? {{(32-NPINS){1'b0}}, rd_value}
                  : hit_dir ? {{(32-NPINS){1'b0}}, pin_direction_r}
                  : hit_opt ? {{(32-NPINS){1'b0}}, pin_option_r}
                  : hit_sens ? {30'h0, ext_irq_sensitivity_ctrl_r}
                  : 32'h0;

    assign pready = 1'b1;
    assign pslverr = acc && !hit_any;
    assign prdata = prdata_r;

    // register writes, byte lane 0 holds all fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_value_reg_r <= GPX_RST_PORT;
            pin_direction_r <= GPX_RST_PORT;
            pin_option_r <= GPX_RST_PORT;
            ext_irq_sensitivity_ctrl_r <= GPX_RST_SENS;
        end else if (wr_acc) begin
            if (hit_value) begin
                port_value_reg_r <= pwdata[NPINS-1:0];
            end
            if (hit_dir) begin
                pin_direction_r <= pwdata[NPINS-1:0];
            end
            if (hit_opt) begin
                pin_option_r <= pwdata[NPINS-1:0];
            end
            if (hit_sens) begin
                ext_irq_sensitivity_ctrl_r <= pwdata[1:0];
            end
        end
    end

    // pin history, pending latch, read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_r <= GPX_RST_PORT;
            pend_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pin_prev_r <= pin_i;
            pend_r <= pend_nxt;
            prdata_r <= (psel && !penable && !pwrite) ? rd_mux : prdata_r;
        end
    end

    // checks
    chk_fetch_clears: assert property (@(posedge pclk) disable iff (!presetn)
        vector_fetch && !any_evt |=> !pend_r)
        else $error("pending survived vector fetch");
    chk_sens_clears: assert property (@(posedge pclk) disable iff (!presetn)
        sens_wr && !any_evt |=> !pend_r)
        else $error("pending survived sensitivity write");
    chk_evt_sets: assert property (@(posedge pclk) disable iff (!presetn)
        any_evt |=> pend_r)
        else $error("qualified event lost");
    chk_mask_gates: assert property (@(posedge pclk) disable iff (!presetn)
        ext_irq_req |-> pend_r && !cpu_irq_masked)
        else $error("request while masked");
    chk_noirq_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_mode == '0) && !pend_r |=> !pend_r)
        else $error("request without interrupt input");
    chk_out_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_value) |=>
        (prdata[NPINS-1:0] & $past(pin_direction_r))
        == ($past(port_value_reg_r) & $past(pin_direction_r)))
        else $error("output read not latch");

    // value bits follow the written word
    chk_wr_value: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hit_value |=> port_value_reg_r == $past(pwdata[NPINS-1:0]))
        else $error("value write lost");

    // direction bits follow the written word
    chk_wr_dir: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hit_dir |=> pin_direction_r == $past(pwdata[NPINS-1:0]))
        else $error("direction write lost");

    // option bits follow the written word
    chk_wr_opt: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hit_opt |=> pin_option_r == $past(pwdata[NPINS-1:0]))
        else $error("option write lost");

    // sensitivity field follows the written word
    chk_wr_sens: assert property (@(posedge pclk) disable iff (!presetn)
        sens_wr |=> ext_irq_sensitivity_ctrl_r == $past(pwdata[1:0]))
        else $error("sensitivity write lost");

    // without a write the port setup stays put
    chk_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_acc |=> $stable(pin_direction_r) && $stable(pin_option_r)
        && $stable(port_value_reg_r))
        else $error("port setup moved without write");

    // latch keeps its state unless set or cleared
    chk_pend_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !any_evt && !vector_fetch && !sens_wr |=> pend_r == $past(pend_r))
        else $error("pending changed by itself");

    // a masked request still wakes the device
    chk_wake_mask: assert property (@(posedge pclk) disable iff (!presetn)
        pend_r && cpu_irq_masked |-> wake_req && !ext_irq_req)
        else $error("masked request handling wrong");

    // hidden latch reads back as zero
    chk_pend_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit_pend |=> prdata == 32'h0)
        else $error("pending latch readable");

    // upper read bits are always zero
    chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite |=> prdata[31:NPINS] == '0)
        else $error("upper read bits set");

    // unmapped access flags an error
    chk_err_flag: assert property (@(posedge pclk) disable iff (!presetn)
        acc |-> pslverr == !hit_any)
        else $error("error flag wrong");

    // per-pin pad, read and event checks
    generate
        for (g = 0; g < NPINS; g++) begin : g_chk
            wire logic [1:0] ck_kind = PIN_KIND[2*g +: 2];
            wire logic ck_tod = (ck_kind == GPX_KIND_TOD);
            wire logic ck_dir = pin_direction_r[g];
            wire logic ck_opt = pin_option_r[g];
            wire logic ck_alt = alt_i[g].out_en;
            wire logic ck_rd = psel && !penable && !pwrite && hit_value;
            wire logic [1:0] ck_sens = ext_irq_sensitivity_ctrl_r;

            // peripheral push-pull drive reaches the pad
            chk_alt_force: assert property (@(posedge pclk) disable iff (!presetn)
                ck_alt && !alt_i[g].out_od && !ck_tod |-> !pad_o[g].oe_n
                && pad_o[g].o == alt_i[g].out_val)
                else $error("alt drive not forced");

            // input pin without peripheral stays undriven
            chk_input_float: assert property (@(posedge pclk) disable iff (!presetn)
                !ck_dir && !ck_alt |-> pad_o[g].oe_n)
                else $error("input pin driven");

            // open-drain high leaves the pad floating
            chk_od_float: assert property (@(posedge pclk) disable iff (!presetn)
                !ck_alt && ck_dir && !ck_opt && port_value_reg_r[g] |-> pad_o[g].oe_n)
                else $error("open-drain high driven");

            // true open-drain never drives high
            chk_tod_float: assert property (@(posedge pclk) disable iff (!presetn)
                ck_tod && !ck_alt && ck_dir && port_value_reg_r[g] |-> pad_o[g].oe_n)
                else $error("true open-drain driven high");

            // output low is driven low in either style
            chk_out_low: assert property (@(posedge pclk) disable iff (!presetn)
                !ck_alt && ck_dir && !port_value_reg_r[g] |-> !pad_o[g].oe_n
                && !pad_o[g].o)
                else $error("output low not driven");

            // push-pull drives the latch level
            chk_pp_drive: assert property (@(posedge pclk) disable iff (!presetn)
                !ck_alt && ck_dir && ck_opt && !ck_tod |-> !pad_o[g].oe_n
                && pad_o[g].o == port_value_reg_r[g])
                else $error("push-pull level wrong");

            // true open-drain has no pull-up
            chk_tod_nopull: assert property (@(posedge pclk) disable iff (!presetn)
                ck_tod |-> !pad_o[g].pull_up)
                else $error("pull-up on true open-drain");

            // standard pin with option set pulls up in input
            chk_pull_std: assert property (@(posedge pclk) disable iff (!presetn)
                ck_kind == GPX_KIND_STD && !ck_dir && !ck_alt && ck_opt |-> pad_o[g].pull_up)
                else $error("standard pull-up missing");

            // interrupt pin with pull-up variant pulls up
            chk_pull_irq: assert property (@(posedge pclk) disable iff (!presetn)
                ck_kind == GPX_KIND_IRQ_PU && !ck_dir && !ck_alt && ck_opt |-> pad_o[g].pull_up)
                else $error("interrupt pull-up missing");

            // floating interrupt variant never pulls up
            chk_irqfl_nopull: assert property (@(posedge pclk) disable iff (!presetn)
                ck_kind == GPX_KIND_IRQ_FL |-> !pad_o[g].pull_up)
                else $error("pull-up on floating interrupt pin");

            // option clear means floating
            chk_float_opt0: assert property (@(posedge pclk) disable iff (!presetn)
                !ck_opt |-> !pad_o[g].pull_up)
                else $error("pull-up with option clear");

            // output direction feeds latch to peripheral
            chk_alt_in_latch: assert property (@(posedge pclk) disable iff (!presetn)
                ck_dir |-> alt_in_o[g] == port_value_reg_r[g])
                else $error("peripheral input not latch");

            // input direction feeds pin to peripheral
            chk_alt_in_pin: assert property (@(posedge pclk) disable iff (!presetn)
                !ck_dir |-> alt_in_o[g] == pin_i[g])
                else $error("peripheral input not pin");

            // input read returns the pin level
            chk_in_read: assert property (@(posedge pclk) disable iff (!presetn)
                ck_rd && !ck_dir && !ck_alt |=> prdata[g] == $past(pin_i[g]))
                else $error("input read not pin");

            // input read with alt output returns alt level
            chk_alt_read: assert property (@(posedge pclk) disable iff (!presetn)
                ck_rd && !ck_dir && ck_alt |=> prdata[g] == $past(alt_i[g].out_val))
                else $error("alt output not read back");

            // low level sets the latch
            chk_level_evt: assert property (@(posedge pclk) disable iff (!presetn)
                irq_mode[g] && ck_sens == GPX_SENS_FALL_LOW && !pin_i[g] |=> pend_r)
                else $error("low level missed");

            // rising edge sets the latch
            chk_rise_evt: assert property (@(posedge pclk) disable iff (!presetn)
                irq_mode[g] && ck_sens == GPX_SENS_RISE && pin_i[g] && !pin_prev_r[g]
                |=> pend_r)
                else $error("rising edge missed");

            // falling edge sets the latch
            chk_fall_evt: assert property (@(posedge pclk) disable iff (!presetn)
                irq_mode[g] && ck_sens == GPX_SENS_FALL && !pin_i[g] && pin_prev_r[g]
                |=> pend_r)
                else $error("falling edge missed");
        end
    endgenerate
endmodule

// *** verilog/gpx_pkg.sv ***
// Purpose: shared constants and types for the gpio port block
// Assumes: 32-bit APB, one aligned word per register
// Notes: pin kinds select per-pin pad capability

package gpx_pkg;
    localparam int GPX_PINS = 8;
    // register byte offsets
    localparam logic [11:0] GPX_OFF_VALUE = 12'h000;
    localparam logic [11:0] GPX_OFF_DIR = 12'h004;
    localparam logic [11:0] GPX_OFF_OPT = 12'h008;
    localparam logic [11:0] GPX_OFF_SENS = 12'h00C;
    localparam logic [11:0] GPX_OFF_PEND = 12'h010;
    // reset values
    localparam logic [7:0] GPX_RST_PORT = 8'h00;
    localparam logic [1:0] GPX_RST_SENS = 2'h0;
    // sensitivity field codes
    localparam logic [1:0] GPX_SENS_FALL_LOW = 2'h0;
    localparam logic [1:0] GPX_SENS_RISE = 2'h1;
    localparam logic [1:0] GPX_SENS_FALL = 2'h2;
    localparam logic [1:0] GPX_SENS_BOTH = 2'h3;
    // pin pad kinds
    localparam logic [1:0] GPX_KIND_STD = 2'h0;
    localparam logic [1:0] GPX_KIND_IRQ_PU = 2'h1;
    localparam logic [1:0] GPX_KIND_IRQ_FL = 2'h2;
    localparam logic [1:0] GPX_KIND_TOD = 2'h3;

    // peripheral claim on one pin
    typedef struct packed {
        logic out_en;   // peripheral drives the pin
        logic out_val;  // level it drives
        logic out_od;   // open-drain style drive
        logic in_en;    // peripheral takes the pin as input
    } gpx_alt_t;

    // pad control for one pin
    typedef struct packed {
        logic o;
        logic oe_n;
        logic pull_up;
    } gpx_pad_t;
endpackage

// *** sim/gpx_pins.sv ***
// Purpose: pin-side model of the gpio port block
// Assumes: outside drivers and pad pull-ups only
// Notes: an undriven pin shows the inverse of its last level
`timescale 1ns/1ps
module gpx_pins
    import gpx_pkg::*;
(
    input wire logic clk,              // bench clock
    input wire gpx_pad_t [7:0] pad,    // pad controls
    input wire logic [7:0] ext_en,     // outside driver on
    input wire logic [7:0] ext_val,    // outside driver level
    output logic [7:0] pin             // resolved levels
);
    logic [7:0] last_r = 8'h00;
    // pad wins, then outside driver, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin[i] = !pad[i].oe_n ? pad[i].o : ext_en[i] ? ext_val[i]
                : pad[i].pull_up ? 1'b1 : ~last_r[i];
        end
    end
    // last level seen on each pin
    always_ff @(posedge clk) last_r <= pin;
endmodule

// *** sim/tb.sv ***
// Purpose: self-checking bench for the gpio port block
// Assumes: zero-wait apb slave, pins modelled by gpx_pins
// Notes: reads queue their expected word, a monitor compares
`timescale 1ns/1ps
module tb;
    import gpx_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, msk, fetch, irq, wake;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] pin, ext_en, ext_val, alt_in, v, d, o;
    logic [3:0] strb;
    gpx_pad_t [7:0] pad;
    gpx_alt_t [7:0] alt;
    logic [31:0] exp_q[$];
    int fail_count = 0;
    int total_checks = 0;
    gpx_port #(.NPINS(8), .PIN_KIND({GPX_KIND_TOD, GPX_KIND_STD, {6{GPX_KIND_IRQ_PU}}})) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_i(pin), .pad_o(pad), .alt_i(alt), .alt_in_o(alt_in),
        .cpu_irq_masked(msk), .vector_fetch(fetch), .ext_irq_req(irq), .wake_req(wake));
    gpx_pins pins (.clk(pclk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin(pin));
    // clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        chk("pslverr", 32'(a > GPX_OFF_PEND), 32'(pslverr));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic pads(input logic [7:0] dd, input logic [7:0] oo, input logic [7:0] vv);
        logic dr;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            dr = dd[i] & (~vv[i] | (oo[i] & (i != 7)));
            chk("oe_n", 32'(!dr), 32'(pad[i].oe_n));
            if (dr) chk("o", 32'(vv[i]), 32'(pad[i].o));
            chk("pull_up", 32'(~dd[i] & oo[i] & (i != 7)), 32'(pad[i].pull_up));
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // read monitor takes the oldest expected word
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) chk("prdata", exp_q.pop_front(), prdata);
    end
    // watchdog
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, msk, fetch} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        alt = '0;
        strb = 4'hF;
        ext_en = 8'hFF;
        void'($urandom(56486));
        ext_val = 8'($urandom);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        pads(8'h00, 8'h00, 8'h00);
        rd(GPX_OFF_DIR, 32'h0);
        rd(GPX_OFF_VALUE, {24'h0, ext_val});
        v = 8'($urandom);
        o = 8'($urandom);
        d = 8'($urandom);
        apb(1'b1, GPX_OFF_VALUE, {24'h0, v});
        apb(1'b1, GPX_OFF_OPT, {24'h0, o});
        pads(8'h00, o, v);
        apb(1'b1, GPX_OFF_DIR, {24'h0, d});
        pads(d, o, v);
        rd(GPX_OFF_VALUE, {24'h0, (d & v) | (~d & ext_val)});
        rd(GPX_OFF_PEND, 32'h0);
        rd(12'h014, 32'h0);
        // lane 0 strobe low ignores the write
        strb <= 4'h0;
        apb(1'b1, GPX_OFF_DIR, 32'hFF);
        strb <= 4'hF;
        rd(GPX_OFF_DIR, {24'h0, d});
        // peripheral claims on floating inputs 4 and 5 and on output pin 2
        apb(1'b1, GPX_OFF_OPT, 32'h0);
        apb(1'b1, GPX_OFF_DIR, 32'h04);
        alt[5] <= 4'b1101;
        alt[4] <= 4'b1010;
        alt[2] <= 4'b0001;
        repeat (2) @(posedge pclk);
        chk("alt_oe_n", 32'h0, 32'({pad[5].oe_n, pad[4].oe_n}));
        chk("alt_o", 32'h2, 32'({pad[5].o, pad[4].o}));
        chk("alt_in", 32'({1'b1, v[2]}), 32'({alt_in[5], alt_in[2]}));
        rd(GPX_OFF_VALUE, {24'h0, (ext_val & 8'hCB) | 8'h20 | {5'h0, v[2], 2'h0}});
        alt <= '0;
        // one sensitivity code per pin, all pins ored
        apb(1'b1, GPX_OFF_DIR, 32'h0);
        apb(1'b1, GPX_OFF_OPT, 32'h3F);
        ext_val <= 8'hFF;
        @(posedge pclk);
        for (int c = 3; c >= 0; c--) begin
            ext_val[c] <= (c != 1);
            repeat (3) @(posedge pclk);
            apb(1'b1, GPX_OFF_SENS, 32'(c));
            repeat (2) @(posedge pclk);
            chk("irq_idle", 32'h0, 32'(irq));
            ext_val[c] <= (c == 1);
            repeat (3) @(posedge pclk);
            chk("irq_set", 32'h3, 32'({irq, wake}));
            fetch <= 1'b1;
            @(posedge pclk);
            fetch <= 1'b0;
            repeat (2) @(posedge pclk);
            chk("irq_fetch", 32'(c == 0), 32'(irq));
            ext_val[c] <= 1'b1;
            @(posedge pclk);
        end
        msk <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("masked", 32'h1, 32'({irq, wake}));
        msk <= 1'b0;
        ext_val <= 8'hFF;
        repeat (3) @(posedge pclk);
        apb(1'b1, GPX_OFF_SENS, 32'h1);
        ext_val <= 8'h00;
        repeat (3) @(posedge pclk);
        ext_val <= 8'hC0;
        repeat (3) @(posedge pclk);
        chk("no_irq_mode", 32'h0, 32'({irq, wake}));
        test_done();
    end
endmodule
